// *** logic/spr_pkg.sv ***
// Constants and types shared by the receive status and user bit buffer
//////////////////////////////////////////////////////////////////////////////
// Contract
// RULE_01 - Hold each channel's 192 status bits as 24 bytes.
// RULE_02 - With autobuffering on, copy received status and user bits to transmitter.
// RULE_03 - Status window occupies 24 byte registers at 0x20 to 0x37.
// RULE_04 - Host writes user offset; data register read returns byte there.
// RULE_05 - Each user data read advances the indirect address by one.
// RULE_06 - Fill work buffer continuously; copy after 192 bits of A and B.
// RULE_07 - Readable buffer keeps both channels; select bit picks A or B.
// RULE_08 - Block flag on new block, or on change of first five bytes.
// RULE_09 - User buffer size 384 bits or 768 bits, starting at Z.
// RULE_10 - Config 00 ignore, 01 double buffer, 10 professional or IEC format.
// RULE_11 - Automatic mode: status byte 1 bits 7:4 choose user behaviour.
// RULE_12 - Buffer filled and mask set raises user buffer full flag.
// RULE_13 - IEC format: drop zero padding, store only information units.
// RULE_14 - More than eight zeros ends message; publish and restart search.
// RULE_15 - Information unit byte holds 1, Q, R, S, T, U, V, W.
// RULE_16 - After 96 units gather Q bits into 10 byte subcode buffer.
// RULE_17 - Check Q subcode with final 16 bits as CRC; flag errors.
// RULE_18 - CRC error flag sticky until its register is read.
// RULE_19 - CRC polynomial x16+x12+x5+1 against inverted transmitted remainder.
// RULE_20 - Indirect address wraps to zero after last configured location.
//////////////////////////////////////////////////////////////////////////////
package spr_pkg;

   localparam int unsigned CS_BITS   = 192;
   localparam int unsigned CS_BYTES  = 24;
   localparam int unsigned CMP_BITS  = 40;
   localparam int unsigned UB_WORDS  = 96;
   localparam int unsigned Q_BITS    = 96;
   localparam int unsigned Q_DATA    = 80;

   // Register indices; byte address is four times the index
   localparam logic [7:0] A_CONFIG   = 8'h10;
   localparam logic [7:0] A_STATUS   = 8'h11;
   localparam logic [7:0] A_UADDR    = 8'h12;
   localparam logic [7:0] A_UDATA    = 8'h13;
   localparam logic [7:0] A_QSUB     = 8'h14;
   localparam logic [7:0] A_QSUB_END = 8'h1d;
   localparam logic [7:0] A_CS_FIRST = 8'h20;
   localparam logic [7:0] A_CS_LAST  = 8'h37;

   // Config register fields and reset value
   localparam int unsigned CFG_SIZE  = 0;
   localparam int unsigned CFG_MODE  = 1;
   localparam int unsigned CFG_FN    = 3;
   localparam int unsigned CFG_SEL   = 4;
   localparam int unsigned CFG_AUTO  = 5;
   localparam int unsigned CFG_UMASK = 6;
   localparam logic [7:0]  CFG_RST   = 8'h00;

   // Status register fields
   localparam int unsigned ST_CS     = 0;
   localparam int unsigned ST_UB     = 1;
   localparam int unsigned ST_QERR   = 2;

   localparam logic [7:0]  LAST_FRAME   = 8'hbf;
   localparam logic [9:0]  UB_BITS_S    = 10'h180;
   localparam logic [9:0]  UB_BITS_L    = 10'h300;
   localparam logic [6:0]  UB_BYTES_S   = 7'h30;
   localparam logic [6:0]  UB_BYTES_L   = 7'h60;
   localparam logic [6:0]  IU_MAX       = 7'h60;
   localparam logic [3:0]  ZERO_GAP     = 4'h8;
   localparam logic [15:0] CRC_POLY     = 16'h1021;
   localparam logic [15:0] CRC_INIT     = 16'h0000;

   typedef enum {SPR_UB_IGNORE, SPR_UB_RAW, SPR_UB_IEC} spr_umode_t;

endpackage

// *** logic/spr_q_if.sv ***
// Carrier between the user bit path and the Q subcode checker
`timescale 1ns/1ps
`default_nettype none
interface spr_q_if;
   logic        iu_stb;
   logic        q_bit;
   logic        restart;
   logic [79:0] q_data;
   logic        done;
   logic        crc_err;
   modport src (output iu_stb, output q_bit, output restart, input q_data, input done, input crc_err);
   modport chk (input iu_stb, input q_bit, input restart, output q_data, output done, output crc_err);
endinterface
`default_nettype wire

// *** logic/spr_qcrc.sv ***
// Q subcode gatherer and CRC checker
`timescale 1ns/1ps
`default_nettype none
module spr_qcrc
   import spr_pkg::*;
(
   input  wire logic core_clk_i,
   input  wire logic rst_n_i,
   spr_q_if.chk      q
);
   import spr_pkg::*;

   logic [95:0] sreg;
   logic [6:0]  cnt;
   logic [15:0] crc;
   logic [95:0] full;

   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
      logic fb;
      fb = c[15] ^ b;
      crc_step = {c[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
   endfunction

   assign full = {sreg[94:0], q.q_bit};

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i || q.restart) begin
         cnt  <= 7'h00;
         sreg <= '0;
         crc  <= CRC_INIT;
      end else if (q.iu_stb && cnt < 7'(Q_BITS)) begin
         sreg <= full;
         cnt  <= cnt + 7'h01;
         if (cnt < 7'(Q_DATA)) begin
            crc <= crc_step(crc, q.q_bit); // RULE_19
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         q.q_data  <= '0;
         q.done    <= 1'b0;
         q.crc_err <= 1'b0;
      end else begin
         q.done    <= 1'b0;
         q.crc_err <= 1'b0;
         if (!q.restart && q.iu_stb && cnt == 7'(Q_BITS - 1)) begin
            q.q_data  <= full[95:16]; // RULE_16
            q.done    <= 1'b1;
            q.crc_err <= (crc != ~full[15:0]); // RULE_17 RULE_19
         end
      end
   end

   property p_crc_check;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (!q.restart && q.iu_stb && cnt == 7'd95) |=> q.done && (q.crc_err == ($past(crc) != ~$past(full[15:0])));
   endproperty
   a_crc_check: assert property (p_crc_check) else $error("Q subcode CRC verdict wrong"); // RULE_17

endmodule
`default_nettype wire

// *** logic/spr_rx_buf.sv ***
// Receive channel status and user bit buffers with Avalon-MM register access
//
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module spr_rx_buf
   import spr_pkg::*;
(
   input  wire logic        core_clk_i,
   input  wire logic        rst_n_i,
   input  wire logic [7:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   output logic      [31:0] avs_readdata_o,
   output logic             avs_waitrequest_o,
   input  wire logic        link_clk_i,
   input  wire logic        link_preamble_z_i,
   input  wire logic        link_chan_b_i,
   input  wire logic        link_cs_bit_i,
   input  wire logic        link_user_bit_i,
   output logic             tx_copy_stb_o,
   output logic             tx_copy_chan_b_o,
   output logic             tx_copy_z_o,
   output logic             tx_copy_cs_bit_o,
   output logic             tx_copy_user_bit_o
);
   import spr_pkg::*;

   //////////////////////////////////////////////////////////////////////////
   // Link sampling: link clock, flags and bits all pass two flip-flops
   logic [4:0] sync1;
   logic [4:0] sync2;
   logic       clk_d;
   logic       sf;
   logic       z;
   logic       chb;
   logic       csb;
   logic       ub;

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         sync1 <= 5'h00;
         sync2 <= 5'h00;
         clk_d <= 1'b0;
      end else begin
         sync1 <= {link_clk_i, link_preamble_z_i, link_chan_b_i, link_cs_bit_i, link_user_bit_i};
         sync2 <= sync1;
         clk_d <= sync2[4];
      end
   end

   // Data is taken on the link clock's rising edge; the source must change it on the falling edge
   assign sf  = sync2[4] & ~clk_d;
   assign z   = sync2[3];
   assign chb = sync2[2];
   assign csb = sync2[1];
   assign ub  = sync2[0];

   //////////////////////////////////////////////////////////////////////////
   // Bus slave: one wait state on every access
   logic       ack;
   logic       rd_fire;
   logic       wr_fire;
   logic [7:0] cfg;
   logic [6:0] uaddr;
   logic [2:0] stat;
   logic       stat_rd;

   assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack;
   assign rd_fire = avs_read_i & ~ack;
   assign wr_fire = avs_write_i & ~ack;
   assign stat_rd = rd_fire && avs_address_i == A_STATUS;

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         ack <= 1'b0;
      end else begin
         ack <= rd_fire | wr_fire;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         cfg <= CFG_RST;
      end else if (wr_fire && avs_address_i == A_CONFIG) begin
         cfg <= avs_writedata_i[7:0];
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Channel status capture
   logic [191:0] cs_work_a;
   logic [191:0] cs_work_b;
   logic [191:0] cs_buf_a;
   logic [191:0] cs_buf_b;
   logic [191:0] next_b;
   logic [7:0]   fcnt;
   logic [7:0]   cur_frame;
   logic         in_blk;
   logic         xfer;
   logic         cs_changed;

   function automatic logic [7:0] cs_byte(input logic [191:0] b, input logic [7:0] idx);
      cs_byte = b[8 * idx[4:0] +: 8];
   endfunction

   assign cur_frame  = z ? 8'h00 : fcnt;
   assign next_b     = {csb, cs_work_b[190:0]};
   assign xfer       = sf && chb && in_blk && cur_frame == LAST_FRAME; // RULE_06
   assign cs_changed = (cs_buf_a[CMP_BITS-1:0] != cs_work_a[CMP_BITS-1:0]) ||
                       (cs_buf_b[CMP_BITS-1:0] != next_b[CMP_BITS-1:0]);

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         fcnt      <= 8'h00;
         in_blk    <= 1'b0;
         cs_work_a <= '0;
         cs_work_b <= '0;
      end else if (sf) begin
         if (z) begin
            in_blk <= 1'b1;
         end
         if (chb) begin
            cs_work_b[cur_frame] <= csb; // RULE_06
            fcnt <= (cur_frame == LAST_FRAME) ? 8'h00 : cur_frame + 8'h01;
         end else begin
            cs_work_a[cur_frame] <= csb;
            fcnt <= cur_frame;
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         cs_buf_a <= '0;
         cs_buf_b <= '0;
      end else if (xfer) begin
         cs_buf_a <= cs_work_a; // RULE_01 RULE_07
         cs_buf_b <= next_b;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // User bit mode, from config or from professional status byte 1
   spr_umode_t umode;
   logic       ularge;
   logic [6:0] ulimit;

   always_comb begin
      umode  = SPR_UB_IGNORE;
      ularge = cfg[CFG_SIZE]; // RULE_09
      unique case (cfg[CFG_MODE +: 2]) // RULE_10
         2'b01: umode = SPR_UB_RAW;
         2'b10: begin
            if (!cs_buf_a[0]) begin
               umode = SPR_UB_IEC;
            end else begin
               unique case (cs_buf_a[15:12]) // RULE_11
                  4'b0100, 4'b1100: umode = SPR_UB_RAW;
                  4'b1000: begin
                     umode  = SPR_UB_RAW;
                     ularge = 1'b0;
                  end
                  default: umode = SPR_UB_IGNORE;
               endcase
            end
         end
         default: umode = SPR_UB_IGNORE;
      endcase
      if (umode == SPR_UB_IEC) begin
         ulimit = IU_MAX;
      end else begin
         ulimit = ularge ? UB_BYTES_L : UB_BYTES_S;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // User bit collection and double buffer
   logic [7:0] u_work [UB_WORDS];
   logic [7:0] u_buf  [UB_WORDS];
   logic [7:0] sh;
   logic [7:0] ubyte;
   logic [9:0] bitcnt;
   logic       urun;
   logic [2:0] iu_bit;
   logic       in_iu;
   logic [6:0] iu_cnt;
   logic [3:0] zc;
   logic       pub_pend;
   logic       raw_done;
   logic       iu_done;
   logic       msg_end;
   spr_q_if    qi ();

   assign ubyte    = {sh[6:0], ub};
   assign raw_done = sf && umode == SPR_UB_RAW && (urun || (z && !chb)) &&
                     bitcnt == (ularge ? UB_BITS_L : UB_BITS_S) - 10'h001;
   assign iu_done  = sf && umode == SPR_UB_IEC && in_iu && iu_bit == 3'h7;
   assign msg_end  = sf && umode == SPR_UB_IEC && !in_iu && !ub && zc == ZERO_GAP && iu_cnt != 7'h00; // RULE_14

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i || umode == SPR_UB_IGNORE) begin
         sh     <= 8'h00;
         bitcnt <= 10'h000;
         urun   <= 1'b0;
         iu_bit <= 3'h0;
         in_iu  <= 1'b0;
         iu_cnt <= 7'h00;
         zc     <= 4'h0;
      end else if (sf && umode == SPR_UB_RAW) begin
         if (urun || (z && !chb)) begin // RULE_09
            sh     <= ubyte;
            urun   <= !raw_done;
            bitcnt <= raw_done ? 10'h000 : ((z && !chb && !urun) ? 10'h001 : bitcnt + 10'h001);
         end
      end else if (sf && umode == SPR_UB_IEC) begin
         if (in_iu) begin
            sh     <= ubyte;
            iu_bit <= iu_bit + 3'h1;
            in_iu  <= !iu_done;
            if (iu_done && iu_cnt < IU_MAX) begin
               iu_cnt <= iu_cnt + 7'h01;
            end
         end else if (ub) begin
            sh     <= 8'h01; // RULE_15
            iu_bit <= 3'h1;
            in_iu  <= 1'b1;
            zc     <= 4'h0;
         end else begin
            zc <= (zc == 4'hf) ? zc : zc + 4'h1; // RULE_13
            if (msg_end) begin
               iu_cnt <= 7'h00;
            end
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         pub_pend <= 1'b0;
         for (int i = 0; i < UB_WORDS; i++) begin
            u_work[i] <= 8'h00;
            u_buf[i]  <= 8'h00;
         end
      end else begin
         pub_pend <= raw_done | msg_end;
         if (sf && umode == SPR_UB_RAW && (urun || (z && !chb)) && bitcnt[2:0] == 3'h7) begin
            u_work[bitcnt[9:3]] <= ubyte;
         end
         if (iu_done && iu_cnt < IU_MAX) begin
            u_work[iu_cnt] <= ubyte; // RULE_13 RULE_15
         end
         if (pub_pend) begin
            u_buf <= u_work; // RULE_14
         end
      end
   end

   assign qi.iu_stb  = iu_done && iu_cnt < IU_MAX;
   assign qi.q_bit   = sh[5];
   assign qi.restart = msg_end || umode != SPR_UB_IEC; // RULE_14

   spr_qcrc u_qcrc (
      .core_clk_i (core_clk_i),
      .rst_n_i    (rst_n_i),
      .q          (qi.chk)
   );

   //////////////////////////////////////////////////////////////////////////
   // Status flags: hardware set wins over the clear by read
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         stat <= 3'h0;
      end else begin
         stat[ST_CS]   <= (xfer && (!cfg[CFG_FN] || cs_changed)) || (stat[ST_CS] && !stat_rd); // RULE_08
         stat[ST_UB]   <= (pub_pend && cfg[CFG_UMASK]) || (stat[ST_UB] && !stat_rd); // RULE_12
         stat[ST_QERR] <= qi.crc_err || (stat[ST_QERR] && !stat_rd); // RULE_18
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Indirect user address and read data
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         uaddr <= 7'h00;
      end else if (wr_fire && avs_address_i == A_UADDR) begin
         uaddr <= avs_writedata_i[6:0]; // RULE_04
      end else if (rd_fire && avs_address_i == A_UDATA) begin
         uaddr <= (uaddr >= ulimit - 7'h01) ? 7'h00 : uaddr + 7'h01; // RULE_05 RULE_20
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         avs_readdata_o <= 32'h0000_0000;
      end else if (rd_fire) begin
         avs_readdata_o <= 32'h0000_0000;
         if (avs_address_i >= A_CS_FIRST && avs_address_i <= A_CS_LAST) begin // RULE_03
            avs_readdata_o[7:0] <= cfg[CFG_SEL] ? cs_byte(cs_buf_b, avs_address_i - A_CS_FIRST)
                                                : cs_byte(cs_buf_a, avs_address_i - A_CS_FIRST); // RULE_07
         end else if (avs_address_i >= A_QSUB && avs_address_i <= A_QSUB_END) begin
            avs_readdata_o[7:0] <= qi.q_data[8'(79) - 8'(8) * (avs_address_i - A_QSUB) -: 8]; // RULE_16
         end else begin
            unique case (avs_address_i)
               A_CONFIG: avs_readdata_o[7:0] <= cfg;
               A_STATUS: avs_readdata_o[2:0] <= stat;
               A_UADDR:  avs_readdata_o[6:0] <= uaddr;
               A_UDATA:  avs_readdata_o[7:0] <= u_buf[uaddr]; // RULE_04
               default:  avs_readdata_o      <= 32'h0000_0000;
            endcase
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Autobuffer copy to the transmitter, one subframe at a time
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         tx_copy_stb_o      <= 1'b0;
         tx_copy_chan_b_o   <= 1'b0;
         tx_copy_z_o        <= 1'b0;
         tx_copy_cs_bit_o   <= 1'b0;
         tx_copy_user_bit_o <= 1'b0;
      end else begin
         tx_copy_stb_o <= sf && cfg[CFG_AUTO]; // RULE_02
         if (sf) begin
            tx_copy_chan_b_o   <= chb;
            tx_copy_z_o        <= z;
            tx_copy_cs_bit_o   <= csb;
            tx_copy_user_bit_o <= ub;
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Checks
   property p_bus_answer;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (avs_read_i && !ack) |-> avs_waitrequest_o ##1 !avs_waitrequest_o;
   endproperty
   a_bus_answer: assert property (p_bus_answer) else $error("Read not answered after one wait state"); // RULE_04

   property p_cs_xfer;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      xfer |=> (cs_buf_a == $past(cs_work_a)) && (cs_buf_b == $past(next_b));
   endproperty
   a_cs_xfer: assert property (p_cs_xfer) else $error("Status block not transferred"); // RULE_06

   property p_cs_flag;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (xfer && !cfg[CFG_FN]) |=> stat[ST_CS];
   endproperty
   a_cs_flag: assert property (p_cs_flag) else $error("Status block flag not set"); // RULE_08

   property p_cs_sel;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (rd_fire && avs_address_i == A_CS_FIRST && cfg[CFG_SEL]) |=> avs_readdata_o[7:0] == $past(cs_buf_b[7:0]);
   endproperty
   a_cs_sel: assert property (p_cs_sel) else $error("Channel select ignored"); // RULE_07

   property p_uaddr_step;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (rd_fire && avs_address_i == A_UDATA) |=> (uaddr == $past(uaddr) + 7'h01) || (uaddr == 7'h00);
   endproperty
   a_uaddr_step: assert property (p_uaddr_step) else $error("User address did not advance"); // RULE_05

   property p_uaddr_wrap;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (rd_fire && avs_address_i == A_UDATA && uaddr == ulimit - 7'h01) |=> uaddr == 7'h00;
   endproperty
   a_uaddr_wrap: assert property (p_uaddr_wrap) else $error("User address did not wrap"); // RULE_20

   property p_ub_flag;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (raw_done && cfg[CFG_UMASK]) |=> ##1 stat[ST_UB];
   endproperty
   a_ub_flag: assert property (p_ub_flag) else $error("User buffer flag not raised"); // RULE_12

   property p_qerr_sticky;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (stat[ST_QERR] && !stat_rd) |=> stat[ST_QERR];
   endproperty
   a_qerr_sticky: assert property (p_qerr_sticky) else $error("CRC error flag dropped without read"); // RULE_18

   property p_ignore;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (umode == SPR_UB_IGNORE) |=> !pub_pend && !urun && !in_iu && iu_cnt == 7'h00;
   endproperty
   a_ignore: assert property (p_ignore) else $error("User bits stored while ignored"); // RULE_10

endmodule
`default_nettype wire

// *** testbench/spr_src.sv ***
// S/PDIF source model driving subframes into the receive buffer
`timescale 1ns/1ps
`default_nettype none
module spr_src (
   input  wire logic clk_i,
   output var  logic link_clk_o,
   output var  logic z_o,
   output var  logic b_o,
   output var  logic cs_o,
   output var  logic u_o
);
   logic [191:0] cs_a;
   logic [191:0] cs_b;
   int           fcnt;
   initial begin
      {link_clk_o, z_o, b_o, cs_o, u_o} = 5'h00;
      fcnt = 0;
      cs_a = '0;
      cs_b = '0;
   end
   //////////////////////////////////////////////////////////////////////////////
   // Clock stands low between frames; fields past their hold show inverted values
   // One subframe spans 16 core cycles, a 64 ns link clock; fields settle 7 cycles before its rise
   task automatic sub(input logic z, input logic b, input logic c, input logic u);
      @(posedge clk_i);
      {z_o, b_o, cs_o, u_o} <= {z, b, c, u};
      repeat (7) @(posedge clk_i);
      link_clk_o <= 1'h1;
      repeat (8) @(posedge clk_i);
      link_clk_o <= 1'h0;
      {z_o, b_o, cs_o, u_o} <= ~{z, b, c, u};
   endtask
   // Channel A then B; Z marks frame 0 of every 192 frame block
   task automatic frame(input logic ua, input logic ub);
      sub(fcnt == 0, 1'h0, cs_a[fcnt], ua);
      sub(1'h0, 1'h1, cs_b[fcnt], ub);
      fcnt = (fcnt == 191) ? 0 : fcnt + 1;
   endtask
endmodule
`default_nettype wire

// *** testbench/tb_spr_rx_status_user_buffer.sv ***
// Self-checking bench for the receive status and user bit buffer
`timescale 1ns/1ps
`default_nettype none
module tb_spr_rx_status_user_buffer
   import spr_pkg::*;
;
   logic        core_clk_i = 1'h0;
   logic        rst_n_i    = 1'h0;
   logic [7:0]  adr        = 8'h00;
   logic        rd         = 1'h0;
   logic        wr         = 1'h0;
   logic [31:0] wd         = 32'h0;
   logic [31:0] rdata;
   logic        wait_r;
   logic        lclk, lz, lb, lc, lu;
   logic        stb, tz, tbb, tc, tu;
   logic [79:0] qd;
   logic        q [$];
   int          error_cnt  = 0;
   int          cmp_count  = 0;
   int          stb_cnt    = 0;
   always #2 core_clk_i = ~core_clk_i;
   spr_src src (.clk_i(core_clk_i), .link_clk_o(lclk), .z_o(lz), .b_o(lb), .cs_o(lc), .u_o(lu));
   spr_rx_buf dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .avs_address_i(adr), .avs_read_i(rd),
      .avs_write_i(wr), .avs_writedata_i(wd), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_r),
      .link_clk_i(lclk), .link_preamble_z_i(lz), .link_chan_b_i(lb), .link_cs_bit_i(lc),
      .link_user_bit_i(lu), .tx_copy_stb_o(stb), .tx_copy_chan_b_o(tbb), .tx_copy_z_o(tz),
      .tx_copy_cs_bit_o(tc), .tx_copy_user_bit_o(tu));
   //////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Edge gap on entry keeps two requests from landing in one time step
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] r);
      int n;
      n = 0;
      @(posedge core_clk_i);
      adr <= a;
      wd <= {24'h0, d};
      wr <= w;
      rd <= ~w;
      do begin
         @(posedge core_clk_i);
         n++;
      end while (wait_r !== 1'h0 && n < 50);
      r = rdata;
      if (n == 50) chk("waitrequest", 32'h0, 32'h1);
      rd <= 1'h0;
      wr <= 1'h0;
   endtask
   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] r;
      bus(1'h1, a, d, r);
   endtask
   task automatic rreg(input string n, input logic [7:0] a, input logic [31:0] e);
      logic [31:0] r;
      bus(1'h0, a, 8'h00, r);
      chk(n, e, r);
   endtask
   function automatic logic [7:0] ca(input int k);
      return 8'h10 + 8'(k) * 8'h11;
   endfunction
   function automatic logic [15:0] crc(input logic [79:0] d);
      logic [15:0] c;
      c = 16'h0000;
      for (int i = 79; i >= 0; i--) c = {c[14:0], 1'h0} ^ ((c[15] ^ d[i]) ? 16'h1021 : 16'h0000);
      return c;
   endfunction
   task automatic stream();
      for (int i = 0; i < q.size(); i += 2) src.frame(q[i], q[i + 1]);
      q.delete();
   endtask
   // Copy stream fields must match the subframe still on the link
   always @(posedge core_clk_i) begin
      if (stb === 1'h1) begin
         stb_cnt++;
         chk("tx_copy", {28'h0, lz, lb, lc, lu}, {28'h0, tz, tbb, tc, tu});
      end
   end
   //////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      rreg("config", A_CONFIG, {24'h0, CFG_RST});
      rreg("status", A_STATUS, 32'h0);
      rreg("cs_first", A_CS_FIRST, 32'h0);
      rreg("unmapped", 8'h00, 32'h0);
      wreg(A_CS_LAST, 8'hff);
      rreg("cs_last_ro", A_CS_LAST, 32'h0);
      $display("test reset done");
   endtask
   task automatic t_cs();
      int s;
      for (int k = 0; k < 24; k++) begin
         src.cs_a[k*8 +: 8] = ca(k);
         src.cs_b[k*8 +: 8] = ~ca(k);
      end
      wreg(A_CONFIG, 8'h00);
      s = stb_cnt;
      repeat (192) src.frame(1'h0, 1'h0);
      chk("tx_off", s, stb_cnt);
      rreg("cs_flag", A_STATUS, 32'h1);
      rreg("cs_flag_clr", A_STATUS, 32'h0);
      for (int k = 0; k < 24; k++) rreg("cs_a", A_CS_FIRST + 8'(k), {24'h0, ca(k)});
      wreg(A_CONFIG, 8'h10);
      for (int k = 0; k < 24; k++) rreg("cs_b", A_CS_FIRST + 8'(k), {24'h0, ~ca(k)});
      $display("test status block done");
   endtask
   task automatic t_fn();
      wreg(A_CONFIG, 8'h08);
      repeat (192) src.frame(1'h0, 1'h0);
      rreg("same_block", A_STATUS, 32'h0);
      src.cs_a[32] = ~src.cs_a[32];
      repeat (192) src.frame(1'h0, 1'h0);
      rreg("byte4_change", A_STATUS, 32'h1);
      $display("test flag function done");
   endtask
   task automatic t_raw(input logic [7:0] c);
      int s;
      logic [7:0] v;
      s = stb_cnt;
      wreg(A_CONFIG, c);
      for (int j = 0; j < 384; j++) begin
         v = 8'(j / 8) ^ 8'h5a;
         q.push_back(v[7 - j % 8]);
      end
      stream();
      chk("tx_count", s + (c[5] ? 384 : 0), stb_cnt);
      rreg("ub_flag", A_STATUS, 32'h3);
      wreg(A_UADDR, 8'h00);
      for (int k = 0; k < 48; k++) rreg("ub_raw", A_UDATA, {24'h0, 8'(k) ^ 8'h5a});
      rreg("ub_wrap", A_UDATA, 32'h5a);
      rreg("ub_addr", A_UADDR, 32'h1);
      $display("test raw user done");
   endtask
   // Padding of one zero between units, twelve to end the message
   task automatic t_iec(input logic bad, input logic [7:0] cfg, input logic [31:0] st);
      logic [95:0] qv;
      logic [31:0] r;
      qv = {qd, ~crc(qd)} ^ {95'h0, bad};
      wreg(A_CONFIG, cfg);
      repeat (10) q.push_back(1'h0);
      for (int i = 95; i >= 0; i--) begin
         q.push_back(1'h1);
         q.push_back(qv[i]);
         repeat (7) q.push_back(1'h0);
      end
      repeat (12) q.push_back(1'h0);
      stream();
      bus(1'h0, A_STATUS, 8'h00, r);
      chk("iec_flags", st, r & 32'h6);
      rreg("flags_clr", A_STATUS, 32'h0);
      if (!bad) begin
         wreg(A_UADDR, 8'h00);
         for (int i = 0; i < 96; i++) rreg("iu", A_UDATA, {24'h0, 1'h1, qv[95 - i], 6'h0});
         for (int k = 0; k < 10; k++) rreg("q_byte", A_QSUB + 8'(k), {24'h0, qd[79 - 8*k -: 8]});
      end
      $display("test iec user done");
   endtask
   // Professional code 1000 forces the short buffer although the size bit asks for the long one
   task automatic t_auto();
      src.cs_a[15:0] = 16'h8001;
      wreg(A_CONFIG, 8'h45);
      while (src.fcnt != 0) src.frame(1'h0, 1'h0);
      repeat (192) src.frame(1'h0, 1'h0);
      t_raw(8'h45);
      $display("test automatic user done");
   endtask
   //////////////////////////////////////////////////////////////////////////////
   initial begin
      for (int k = 0; k < 10; k++) qd[79 - 8*k -: 8] = 8'h21 + 8'(k) * 8'h1d;
      repeat (16) @(posedge core_clk_i);
      rst_n_i <= 1'h1;
      t_reset();
      t_cs();
      t_fn();
      t_raw(8'h62);
      t_iec(1'h0, 8'h44, 32'h2);
      t_iec(1'h1, 8'h04, 32'h4);
      t_auto();
      summarize();
   end
   initial begin
      #400000;
      error_cnt++;
      summarize();
   end
endmodule
`default_nettype wire
